//--- hdl/twes_pkg.sv
package twes_pkg;
    localparam int          BYTE_W        = 8;
    localparam int          ADDR_W        = 7;
    localparam int          PAGE_OFS_W    = 3;
    localparam int          STRAP_W       = 3;
    localparam int          DEPTH         = 128;
    localparam logic [3:0]  DEV_TYPE_CODE = 4'ha;
    localparam int          DEV_TYPE_MSB  = 7;
    localparam int          STRAP_MSB     = 3;
    localparam int          RW_BIT        = 0;
    localparam int          CLK_PERIOD_PS = 4000;
    localparam int          WRITE_TIME_MS = 5;
    localparam int          WRITE_CYCLES  =
        (WRITE_TIME_MS * 1000000) / (CLK_PERIOD_PS / 1000);
    localparam int          BIT_CNT_W     = 4;
    localparam logic [3:0]  ACK_SLOT      = 4'h8;

    typedef enum logic [2:0] {
        TWES_IDLE  = 3'b000,
        TWES_DEV   = 3'b001,
        TWES_WADDR = 3'b010,
        TWES_WDATA = 3'b011,
        TWES_RDATA = 3'b100,
        TWES_RACK  = 3'b101
    } twes_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } twes_bus_s;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } twes_evt_s;
endpackage

//--- hdl/twes_slave.sv
`timescale 1ns/1ps
// Overview of operation
// - SDA change during SCL high is control
// - SDA fall with SCL high starts
// - SDA rise with SCL high stops
// - Bytes MSB first, acked on ninth clock
// - Standby at reset and after stop
// - Device word top nibble must match
// - Next three bits match strap inputs
// - Last address bit selects read or write
// - Ack on match, else standby
// - Byte write: address, data, stop
// - Write cycle starts at stop, 5 ms
// - Bus ignored during write cycle
// - Page write up to eight bytes
// - Write address wraps inside page
// - Ack polling answered once write ends
// - Address counter keeps last plus one
// - Read address wraps over whole array
// - Current read sends byte at counter
// - Controller ack continues sequential read
// - Sample on SCL rise, drive after fall
// - 128 bytes, seven bit word address
// - Write protect input blocks all writes
module twes_slave #(
    parameter int WRITE_CYCLES = twes_pkg::WRITE_CYCLES
) (
    input  wire logic                          core_clk_i,
    input  wire logic                          reset_i,
    input  wire logic                          scl_i,
    input  wire logic                          sda_i,
    output logic                               sda_o,
    output logic                               sda_oe_n_o,
    input  wire logic [twes_pkg::STRAP_W-1:0]  chip_select_straps_i,
    input  wire logic                          write_protect_i,
    output logic                               busy_o
);
    import twes_pkg::*;

    twes_bus_s                 sync1_r;
    twes_bus_s                 sync2_r;
    twes_bus_s                 prev_r;
    twes_evt_s                 evt;
    twes_state_e               state_r;
    logic [STRAP_W-1:0]        strap_r;
    logic [STRAP_W-1:0]        strap_meta_r;
    logic                      wp_meta_r;
    logic                      wp_r;
    logic [BYTE_W-1:0]         mem_r [DEPTH];
    logic [BYTE_W-1:0]         page_r [1<<PAGE_OFS_W];
    logic [(1<<PAGE_OFS_W)-1:0] page_vld_r;
    logic [ADDR_W-1:0]         addr_r;
    logic [ADDR_W-1:0]         page_base_r;
    logic [BYTE_W-1:0]         shift_r;
    logic [BIT_CNT_W-1:0]      bit_cnt_r;
    logic                      drive_low_r;
    logic                      pend_wr_r;
    logic [31:0]               wr_cnt_r;
    logic                      busy_r;
    logic                      ack_phase;
    logic                      dev_match;
    logic [BYTE_W-1:0]         rx_byte;
    logic [ADDR_W-1:0]         page_next;
    logic [ADDR_W-1:0]         read_next;

    // Pins are asynchronous to core_clk, two stages before any use
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_r <= '{scl: 1'b1, sda: 1'b1};
            sync2_r <= '{scl: 1'b1, sda: 1'b1};
            prev_r  <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            sync1_r <= '{scl: scl_i, sda: sda_i};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // Straps and protect are pins too; static, so no reset is needed
    always_ff @(posedge core_clk_i) begin
        strap_meta_r <= chip_select_straps_i;
        strap_r      <= strap_meta_r;
        wp_meta_r    <= write_protect_i;
        wp_r         <= wp_meta_r;
    end

    assign evt.start = prev_r.scl & sync2_r.scl
                     & prev_r.sda & ~sync2_r.sda;
    assign evt.stop  = prev_r.scl & sync2_r.scl
                     & ~prev_r.sda & sync2_r.sda;
    assign evt.rise  = ~prev_r.scl & sync2_r.scl;
    assign evt.fall  = prev_r.scl & ~sync2_r.scl;

    assign ack_phase = (bit_cnt_r == ACK_SLOT);
    assign rx_byte   = {shift_r[BYTE_W-2:0], sync2_r.sda};
    assign dev_match = (shift_r[DEV_TYPE_MSB -: $bits(DEV_TYPE_CODE)] ==
                        DEV_TYPE_CODE)
                     & (shift_r[STRAP_MSB -: STRAP_W] == strap_r);
    assign page_next = {page_base_r[ADDR_W-1:PAGE_OFS_W],
                        addr_r[PAGE_OFS_W-1:0] + 3'h1};
    assign read_next = addr_r + 7'h01;
    assign busy_o    = busy_r;
    assign sda_o     = 1'b0;
    assign sda_oe_n_o = ~drive_low_r;

    // Protocol engine; busy blocks all bus response
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r     <= TWES_IDLE;
            bit_cnt_r   <= '0;
            shift_r     <= '0;
            drive_low_r <= 1'b0;
            addr_r      <= '0;
            page_base_r <= '0;
            page_vld_r  <= '0;
            pend_wr_r   <= 1'b0;
        end else if (busy_r) begin
            state_r     <= TWES_IDLE;
            drive_low_r <= 1'b0;
            pend_wr_r   <= 1'b0;
            // Valid flags must outlive the stop until the commit reads them
            if (wr_cnt_r == '0) begin
                page_vld_r <= '0;
            end
        end else if (evt.start) begin
            state_r     <= TWES_DEV;
            bit_cnt_r   <= '0;
            drive_low_r <= 1'b0;
        end else if (evt.stop) begin
            state_r     <= TWES_IDLE;
            drive_low_r <= 1'b0;
            pend_wr_r   <= 1'b0;
        end else if (state_r != TWES_IDLE && evt.rise) begin
            if (ack_phase) begin
                if (state_r == TWES_RACK && sync2_r.sda) begin
                    state_r <= TWES_IDLE;
                end
            end else if (state_r != TWES_RDATA &&
                         state_r != TWES_RACK) begin
                shift_r   <= rx_byte;
            end
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (state_r != TWES_IDLE && evt.fall) begin
            drive_low_r <= 1'b0;
            case (state_r)
                TWES_DEV: begin
                    if (bit_cnt_r == ACK_SLOT) begin
                        if (dev_match) begin
                            drive_low_r <= 1'b1;
                        end else begin
                            state_r <= TWES_IDLE;
                        end
                    end else if (bit_cnt_r == ACK_SLOT + 4'h1) begin
                        bit_cnt_r <= '0;
                        if (shift_r[RW_BIT]) begin
                            state_r     <= TWES_RDATA;
                            shift_r     <= mem_r[addr_r];
                            drive_low_r <= ~mem_r[addr_r][BYTE_W-1];
                        end else begin
                            state_r   <= TWES_WADDR;
                            bit_cnt_r <= '0;
                        end
                    end
                end
                TWES_WADDR: begin
                    if (bit_cnt_r == ACK_SLOT) begin
                        drive_low_r <= 1'b1;
                        addr_r      <= shift_r[ADDR_W-1:0];
                        page_base_r <= shift_r[ADDR_W-1:0];
                    end else if (bit_cnt_r == ACK_SLOT + 4'h1) begin
                        state_r   <= TWES_WDATA;
                        bit_cnt_r <= '0;
                    end
                end
                TWES_WDATA: begin
                    if (bit_cnt_r == ACK_SLOT) begin
                        drive_low_r <= 1'b1;
                        if (!wp_r) begin
                            page_vld_r[addr_r[PAGE_OFS_W-1:0]] <= 1'b1;
                            pend_wr_r <= 1'b1;
                        end
                        addr_r <= page_next;
                    end else if (bit_cnt_r == ACK_SLOT + 4'h1) begin
                        bit_cnt_r <= '0;
                    end
                end
                TWES_RDATA, TWES_RACK: begin
                    if (bit_cnt_r == ACK_SLOT) begin
                        state_r <= TWES_RACK;
                        addr_r  <= read_next;
                    end else if (bit_cnt_r == ACK_SLOT + 4'h1) begin
                        state_r     <= TWES_RDATA;
                        bit_cnt_r   <= '0;
                        shift_r     <= mem_r[addr_r];
                        drive_low_r <= ~mem_r[addr_r][BYTE_W-1];
                    end else begin
                        shift_r     <= {shift_r[BYTE_W-2:0], 1'b0};
                        drive_low_r <= ~shift_r[BYTE_W-2];
                    end
                end
                default: state_r <= TWES_IDLE;
            endcase
        end
    end

    // Data byte lands in the page buffer on the eighth rising edge
    always_ff @(posedge core_clk_i) begin
        if (!busy_r && state_r == TWES_WDATA && evt.rise
            && bit_cnt_r == ACK_SLOT - 4'h1) begin
            page_r[addr_r[PAGE_OFS_W-1:0]] <= rx_byte;
        end
    end

    // Self-timed write; buffered page bytes commit when it finishes
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy_r   <= 1'b0;
            wr_cnt_r <= '0;
        end else if (!busy_r && evt.stop && pend_wr_r) begin
            busy_r   <= 1'b1;
            wr_cnt_r <= 32'(WRITE_CYCLES - 1);
        end else if (busy_r) begin
            if (wr_cnt_r == '0) begin
                busy_r <= 1'b0;
            end else begin
                wr_cnt_r <= wr_cnt_r - 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (busy_r && wr_cnt_r == '0) begin
            for (int i = 0; i < (1 << PAGE_OFS_W); i++) begin
                if (page_vld_r[i]) begin
                    mem_r[{page_base_r[ADDR_W-1:PAGE_OFS_W],
                           3'(i)}] <= page_r[i];
                end
            end
        end
    end

    // Last fall of a byte opens the answer slot, the next one closes it
    sequence s_slot_open;
        !busy_r && evt.fall && bit_cnt_r == ACK_SLOT;
    endsequence

    sequence s_slot_close;
        !busy_r && evt.fall && bit_cnt_r == ACK_SLOT + 4'h1;
    endsequence

    property p_stop_starts_write;
        @(posedge core_clk_i) disable iff (reset_i)
        (!busy_r && evt.stop && pend_wr_r) |=> busy_r;
    endproperty
    a_stop_starts_write: assert property (p_stop_starts_write)
        else $error("write cycle did not start at stop");

    property p_quiet_when_busy;
        @(posedge core_clk_i) disable iff (reset_i)
        busy_r |=> ##1 sda_oe_n_o;
    endproperty
    a_quiet_when_busy: assert property (p_quiet_when_busy)
        else $error("bus driven during write cycle");

    property p_protect_no_write;
        @(posedge core_clk_i) disable iff (reset_i)
        (wp_r && !pend_wr_r && state_r == TWES_WDATA) ##0 s_slot_open
        |=> !pend_wr_r;
    endproperty
    a_protect_no_write: assert property (p_protect_no_write)
        else $error("protected write started a cycle");

    property p_start_resets;
        @(posedge core_clk_i) disable iff (reset_i)
        (evt.start && !busy_r) |=> (state_r == TWES_DEV && bit_cnt_r == 0);
    endproperty
    a_start_resets: assert property (p_start_resets)
        else $error("start not recognised");

    property p_stop_idles;
        @(posedge core_clk_i) disable iff (reset_i)
        evt.stop |=> (state_r == TWES_IDLE && sda_oe_n_o);
    endproperty
    a_stop_idles: assert property (p_stop_idles)
        else $error("stop did not return to standby");

    property p_mismatch_no_ack;
        @(posedge core_clk_i) disable iff (reset_i)
        (!busy_r && state_r == TWES_DEV && evt.fall && !evt.start
         && !evt.stop && bit_cnt_r == ACK_SLOT && !dev_match)
        |=> (sda_oe_n_o && state_r == TWES_IDLE);
    endproperty
    a_mismatch_no_ack: assert property (p_mismatch_no_ack)
        else $error("acknowledged a foreign address");

    property p_write_wrap;
        @(posedge core_clk_i) disable iff (reset_i)
        (!busy_r && state_r == TWES_WDATA && evt.fall && !evt.start
         && !evt.stop && bit_cnt_r == ACK_SLOT)
        |=> addr_r[ADDR_W-1:PAGE_OFS_W] ==
            $past(page_base_r[ADDR_W-1:PAGE_OFS_W]);
    endproperty
    a_write_wrap: assert property (p_write_wrap)
        else $error("write address left its page");

    property p_busy_ends;
        @(posedge core_clk_i) disable iff (reset_i)
        (busy_r && wr_cnt_r == 0) |=> !busy_r;
    endproperty
    a_busy_ends: assert property (p_busy_ends)
        else $error("write cycle overran");

    property p_ack_on_match;
        @(posedge core_clk_i) disable iff (reset_i)
        (state_r == TWES_DEV && dev_match) ##0 s_slot_open |=> !sda_oe_n_o;
    endproperty
    a_ack_on_match: assert property (p_ack_on_match)
        else $error("matching address not acknowledged");

    property p_ack_release;
        @(posedge core_clk_i) disable iff (reset_i)
        (state_r == TWES_WADDR || state_r == TWES_WDATA) ##0 s_slot_close
        |=> sda_oe_n_o;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("acknowledge held past the ninth clock");

    property p_data_ack;
        @(posedge core_clk_i) disable iff (reset_i)
        (state_r == TWES_WDATA) ##0 s_slot_open |=> !sda_oe_n_o;
    endproperty
    a_data_ack: assert property (p_data_ack)
        else $error("data byte not acknowledged");

    property p_read_step;
        @(posedge core_clk_i) disable iff (reset_i)
        (state_r == TWES_RDATA) ##0 s_slot_open
        |=> (state_r == TWES_RACK && sda_oe_n_o
             && addr_r == $past(addr_r) + 7'h01);
    endproperty
    a_read_step: assert property (p_read_step)
        else $error("read address did not advance");

    property p_read_begins;
        @(posedge core_clk_i) disable iff (reset_i)
        (state_r == TWES_DEV && shift_r[RW_BIT]) ##0 s_slot_close
        |=> (state_r == TWES_RDATA && bit_cnt_r == '0);
    endproperty
    a_read_begins: assert property (p_read_begins)
        else $error("read byte not started after address");

    property p_nack_ends_read;
        @(posedge core_clk_i) disable iff (reset_i)
        (!busy_r && state_r == TWES_RACK && evt.rise && ack_phase
         && sync2_r.sda) |=> state_r == TWES_IDLE;
    endproperty
    a_nack_ends_read: assert property (p_nack_ends_read)
        else $error("read went on after a missing acknowledge");
endmodule

//--- testbench/twes_ctrl_model.sv
`timescale 1ns/1ps
// Bus controller; sda_o high releases the open-drain line
module twes_ctrl_model (
    input  wire logic core_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // Clock idles high between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // Data moves only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        sda_o <= b;
        tick(4);
        scl_o <= 1'b1;
        tick(4);
        @(negedge core_clk_i);
        r = sda_i;
        tick(4);
        scl_o <= 1'b0;
        tick(4);
    endtask

    // Works as a first or a repeated start
    task automatic send_start();
        sda_o <= 1'b1;
        tick(4);
        scl_o <= 1'b1;
        tick(8);
        sda_o <= 1'b0;
        tick(8);
        scl_o <= 1'b0;
        tick(4);
    endtask

    task automatic send_stop();
        sda_o <= 1'b0;
        tick(4);
        scl_o <= 1'b1;
        tick(8);
        sda_o <= 1'b1;
        tick(8);
    endtask

    // Device word and data go out MSB first
    task automatic put_byte(input logic [7:0] d, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, ack_n);
    endtask

    // Low in the answer slot asks for more
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask

    task automatic recover();
        logic r;
        send_start();
        repeat (9) bit_io(1'b1, r);
        send_start();
        send_stop();
    endtask
endmodule

//--- testbench/twes_slave_bench.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("Error %s expected %h seen %h", nm, exp, got); \
        end \
    end
module twes_slave_bench;
    import twes_pkg::*;
    // Long enough that the first poll lands inside the write cycle
    localparam int WR_CYC = 400;
    logic               core_clk = 1'b0;
    logic               reset    = 1'b1;
    logic [STRAP_W-1:0] straps   = '0;
    logic               wp       = 1'b0;
    logic               scl;
    logic               ctl_sda;
    logic               dev_sda;
    logic               dev_oe_n;
    logic               busy;
    wire                sda_line = ctl_sda & (dev_oe_n | dev_sda);
    int                 err_total = 0;
    int                 n_tests   = 0;
    int                 seed      = 32'haca083a8;
    int                 a;
    int                 n;
    logic [7:0]         ref_mem [DEPTH];
    logic [7:0]         d;
    logic               ack_n;

    always #2 core_clk = ~core_clk;

    twes_slave #(.WRITE_CYCLES(WR_CYC)) twes_slave_inst (
        .core_clk_i           (core_clk),
        .reset_i              (reset),
        .scl_i                (scl),
        .sda_i                (sda_line),
        .sda_o                (dev_sda),
        .sda_oe_n_o           (dev_oe_n),
        .chip_select_straps_i (straps),
        .write_protect_i      (wp),
        .busy_o               (busy)
    );

    twes_ctrl_model twes_ctrl_model_inst (
        .core_clk_i (core_clk),
        .sda_i      (sda_line),
        .scl_o      (scl),
        .sda_o      (ctl_sda)
    );

    task automatic print_verdict();
        $display("Checks %0d, errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Writes wrap inside their page, reads over the whole array
    function automatic int wr_slot(input int adr, input int i);
        return (adr & 'h78) | ((adr + i) & 7);
    endfunction

    function automatic int rd_slot(input int adr, input int i);
        return (adr + i) % DEPTH;
    endfunction

    task automatic dev_word(input logic rw, input logic [7:0] flip,
                            input logic exp_n);
        twes_ctrl_model_inst.send_start();
        twes_ctrl_model_inst.put_byte({DEV_TYPE_CODE, straps, rw} ^ flip,
                                      ack_n);
        `CHK("device ack", exp_n, ack_n)
    endtask

    // Polls with write direction; a stop with no data starts nothing
    task automatic poll();
        int k;
        k = 0;
        do begin
            twes_ctrl_model_inst.send_start();
            twes_ctrl_model_inst.put_byte({DEV_TYPE_CODE, straps, 1'b0},
                                          ack_n);
            if (busy === 1'b1) `CHK("busy refusal", 1'b1, ack_n)
            twes_ctrl_model_inst.send_stop();
            k++;
        end while (ack_n !== 1'b0 && k < 20);
        `CHK("poll ack", 1'b0, ack_n)
        `CHK("busy done", 1'b0, busy)
        if (ack_n !== 1'b0) print_verdict();
    endtask

    task automatic wr_page(input int adr, input int cnt);
        dev_word(1'b0, 8'h00, 1'b0);
        // Top bit of the word address is unused
        twes_ctrl_model_inst.put_byte(8'(adr) | 8'h80, ack_n);
        `CHK("addr ack", 1'b0, ack_n)
        for (int i = 0; i < cnt; i++) begin
            d = 8'($random(seed));
            twes_ctrl_model_inst.put_byte(d, ack_n);
            `CHK("data ack", 1'b0, ack_n)
            if (!wp) ref_mem[wr_slot(adr, i)] = d;
        end
        twes_ctrl_model_inst.send_stop();
        repeat (8) @(posedge core_clk);
        `CHK("write busy", !wp, busy)
        poll();
    endtask

    task automatic rd_seq(input int adr, input int cnt);
        dev_word(1'b0, 8'h00, 1'b0);
        twes_ctrl_model_inst.put_byte(8'(adr), ack_n);
        dev_word(1'b1, 8'h00, 1'b0);
        for (int i = 0; i < cnt; i++) begin
            twes_ctrl_model_inst.get_byte(i == cnt - 1, d);
            `CHK("read data", ref_mem[rd_slot(adr, i)], d)
        end
        twes_ctrl_model_inst.send_stop();
    endtask

    initial begin
        straps <= 3'($random(seed));
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        `CHK("standby release", 1'b1, dev_oe_n)
        dev_word(1'b0, 8'h00, 1'b0);
        twes_ctrl_model_inst.recover();
        for (int p = 0; p < DEPTH; p += 8) wr_page(p, 8);
        dev_word(1'b0, 8'h10, 1'b1);
        twes_ctrl_model_inst.send_stop();
        dev_word(1'b0, 8'h02, 1'b1);
        twes_ctrl_model_inst.send_stop();
        rd_seq(126, 4);
        dev_word(1'b1, 8'h00, 1'b0);
        twes_ctrl_model_inst.get_byte(1'b1, d);
        `CHK("current read", ref_mem[2], d)
        twes_ctrl_model_inst.send_stop();
        // Protected page write: acked, but the old bytes must survive
        wp <= 1'b1;
        @(posedge core_clk);
        wr_page(40, 3);
        wp <= 1'b0;
        rd_seq(40, 3);
        repeat (8) begin
            a = $random(seed) & 127;
            n = 1 + (($random(seed) & 15) % 10);
            wp <= ($random(seed) & 3) == 0;
            @(posedge core_clk);
            wr_page(a, n);
            wp <= 1'b0;
            rd_seq(a & 'h78, 8);
        end
        print_verdict();
    end
endmodule
